// ===== adc_port_pkg.sv
// package for the host-side controller of a 12-bit parallel-readout converter
// assumes one 125 MHz core clock; all times below are in ns and converted to cycles here
package adc_port_pkg;

   // ************************************************************
   // clock and widths
   // ************************************************************
   localparam int CLK_PERIOD_NS = 8;                       // core_clk period
   localparam int RESULT_W      = 12;                      // converter result width
   localparam int BYTE_W        = 8;                       // byte-mode bus width

   // ************************************************************
   // timing figures as printed (ns)
   // ************************************************************
   localparam int T_SEL_MIN_NS     = 20;                   // select low width
   localparam int T_TRIG_HI_NS     = 63;                   // trigger high width
   localparam int T_TRIG_LO_NS     = 20;                   // trigger low width
   localparam int T_QUIET_NS       = 25;                   // quiet time before conversion
   localparam int T_RD_VALID_NS    = 25;                   // read strobe to valid data
   localparam int T_BYTE_VALID_NS  = 25;                   // byte select to low part valid
   localparam int T_BUSY_RISE_NS   = 40;                   // trigger low to busy high
   localparam int T_RESET_MIN_NS   = 45;                   // reset pulse least
   localparam int T_RESET_MAX_NS   = 6140;                 // reset pulse most
   localparam int T_PDOWN_MIN_NS   = 7200;                 // power-down least low time
   localparam int T_PWRUP_NS       = 25;                   // power-up start delay

   // ************************************************************
   // derived cycle counts: least times round up, longest round down
   // ************************************************************
   localparam int C_SEL_MIN    = (T_SEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_TRIG_HI    = (T_TRIG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_TRIG_LO    = (T_TRIG_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_QUIET      = (T_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_RD_VALID   = (T_RD_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_BYTE_VALID = (T_BYTE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_BUSY_RISE  = (T_BUSY_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_RESET_MIN  = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_RESET_MAX  = T_RESET_MAX_NS / CLK_PERIOD_NS;
   localparam int C_PDOWN_MIN  = (T_PDOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int C_PWRUP      = (T_PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ************************************************************
   // counter width and sequencer states
   // ************************************************************
   localparam int CNT_W = 10;                              // covers the power-down count
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;        // counter clear value

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,                                   // waiting for a request
      ST_ACQ     = 4'h1,                                   // trigger high, acquiring
      ST_QUIET   = 4'h2,                                   // bus quiet before conversion
      ST_CONV    = 4'h3,                                   // trigger low, wait for busy
      ST_WAIT    = 4'h4,                                   // wait for busy low
      ST_RD      = 4'h5,                                   // strobe low, full word or high byte
      ST_RD_LO   = 4'h6,                                   // byte select high, low part
      ST_RD_END  = 4'h7,                                   // strobe released, settle
      ST_PIN_LOW = 4'h8,                                   // power-down/reset line low
      ST_PIN_REC = 4'h9                                    // recovery after line release
   } seq_state_e;

endpackage : adc_port_pkg

// ===== adc_port_host.sv
// host controller that drives the converter's select, trigger, read strobe, byte select
// and power-down/reset pins and collects each result
// assumes the converter's busy and data pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module adc_port_host (
   input  wire logic                            core_clk,          // 125 MHz core clock
   input  wire logic                            rst_n,             // async reset, active low
   input  wire logic                            conv_req,          // request one conversion and read
   input  wire logic                            byte_mode,         // read as two bytes when high
   input  wire logic                            reset_req,         // request a device reset pulse
   input  wire logic                            pdown_req,         // hold device powered down while high
   input  wire logic                            busy_pin,          // converter busy output
   input  wire logic [adc_port_pkg::RESULT_W-1:0] result_bus_in,   // converter data bus
   output logic                                 select_n_ff,       // chip select pin, active low
   output logic                                 sample_trigger_ff, // conversion trigger pin
   output logic                                 read_n_ff,         // read strobe pin, active low
   output logic                                 byte_sel_ff,       // byte select pin
   output logic                                 powerdown_reset_n_ff, // power-down/reset pin
   output logic                                 ready_ff,          // controller idle
   output logic                                 result_valid_ff,   // one-cycle pulse with result
   output logic [adc_port_pkg::RESULT_W-1:0]    result_ff,         // collected result
   output logic                                 powered_down_ff    // device held in power-down
);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic                                 busy_meta_ff;             // first stage, read only by second
   logic                                 busy_sync_ff;             // synchronised busy
   logic [adc_port_pkg::RESULT_W-1:0]    data_meta_ff;             // first stage of data bus
   logic [adc_port_pkg::RESULT_W-1:0]    data_sync_ff;             // synchronised data bus

   // both pins come from another chip, so two flops before any logic
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_meta_ff <= 1'b0;
         busy_sync_ff <= 1'b0;
         data_meta_ff <= 12'h000;
         data_sync_ff <= 12'h000;
      end else begin
         busy_meta_ff <= busy_pin;
         busy_sync_ff <= busy_meta_ff;
         data_meta_ff <= result_bus_in;
         data_sync_ff <= data_meta_ff;
      end
   end

   // ************************************************************
   // sequencer
   // ************************************************************
   adc_port_pkg::seq_state_e             state_ff;                 // current state
   logic [adc_port_pkg::CNT_W-1:0]       cnt_ff;                   // cycles spent in state
   logic                                 is_pdown_ff;              // current low pulse is a power-down
   logic                                 byte_mode_ff;             // byte mode latched per read
   logic                                 done_cnt;                 // helper: count reached

   // sync delay of two cycles is added to every wait on a device output
   localparam int SYNC_LAT = 2;

   always_comb begin
      done_cnt = 1'b0;
      unique case (state_ff)
         adc_port_pkg::ST_ACQ:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_TRIG_HI - 1));
         adc_port_pkg::ST_QUIET:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_QUIET - 1));
         adc_port_pkg::ST_CONV:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_BUSY_RISE + SYNC_LAT));
         adc_port_pkg::ST_RD:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_RD_VALID + SYNC_LAT));
         adc_port_pkg::ST_RD_LO:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_BYTE_VALID + SYNC_LAT));
         adc_port_pkg::ST_RD_END:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_QUIET - 1));
         adc_port_pkg::ST_PIN_LOW:
            done_cnt = is_pdown_ff ? 1'b0 : (cnt_ff >= 10'(adc_port_pkg::C_RESET_MIN - 1));
         adc_port_pkg::ST_PIN_REC:
            done_cnt = (cnt_ff >= 10'(adc_port_pkg::C_PWRUP - 1));
         default:
            done_cnt = 1'b0;
      endcase
   end

   // state transitions; the cycle counter restarts on every change of state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff     <= adc_port_pkg::ST_IDLE;
         cnt_ff       <= adc_port_pkg::CNT_ZERO;
         is_pdown_ff  <= 1'b0;
         byte_mode_ff <= 1'b0;
      end else begin
         cnt_ff <= (cnt_ff == 10'h3FF) ? cnt_ff : cnt_ff + 10'h001;
         unique case (state_ff)
            adc_port_pkg::ST_IDLE: begin
               // reset and power-down take priority over a conversion
               if (pdown_req || reset_req) begin
                  state_ff    <= adc_port_pkg::ST_PIN_LOW;
                  is_pdown_ff <= pdown_req;
                  cnt_ff      <= adc_port_pkg::CNT_ZERO;
               end else if (conv_req) begin
                  state_ff     <= adc_port_pkg::ST_ACQ;
                  byte_mode_ff <= byte_mode;
                  cnt_ff       <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_ACQ: begin
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_QUIET;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_QUIET: begin
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_CONV;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_CONV: begin
               // give the device its busy-rise window before watching for the fall
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_WAIT;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_WAIT: begin
               if (!busy_sync_ff) begin
                  state_ff <= adc_port_pkg::ST_RD;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_RD: begin
               if (done_cnt) begin
                  state_ff <= byte_mode_ff ? adc_port_pkg::ST_RD_LO : adc_port_pkg::ST_RD_END;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_RD_LO: begin
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_RD_END;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_RD_END: begin
               // bus must be released and quiet before the next trigger fall
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_IDLE;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_PIN_LOW: begin
               // a power-down lasts while requested, but never shorter than its minimum
               if (done_cnt || (is_pdown_ff && !pdown_req &&
                   cnt_ff >= 10'(adc_port_pkg::C_PDOWN_MIN - 1))) begin
                  state_ff <= adc_port_pkg::ST_PIN_REC;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            adc_port_pkg::ST_PIN_REC: begin
               if (done_cnt) begin
                  state_ff <= adc_port_pkg::ST_IDLE;
                  cnt_ff   <= adc_port_pkg::CNT_ZERO;
               end
            end
            default: begin
               state_ff <= adc_port_pkg::ST_IDLE;
               cnt_ff   <= adc_port_pkg::CNT_ZERO;
            end
         endcase
      end
   end

   // ************************************************************
   // pin drivers, all registered
   // ************************************************************
   // select stays low from acquisition through the read, well over its minimum width;
   // it falls only after the trigger already stands high, so the device takes the
   // select fall as an acquisition start and never as a conversion start
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         select_n_ff          <= 1'b1;
         sample_trigger_ff    <= 1'b0;
         read_n_ff            <= 1'b1;
         byte_sel_ff          <= 1'b0;
         powerdown_reset_n_ff <= 1'b1;
      end else begin
         select_n_ff          <= (state_ff == adc_port_pkg::ST_IDLE) ||
                                 (state_ff == adc_port_pkg::ST_PIN_LOW) ||
                                 (state_ff == adc_port_pkg::ST_PIN_REC) ||
                                 ((state_ff == adc_port_pkg::ST_ACQ) && !sample_trigger_ff);
         sample_trigger_ff    <= (state_ff == adc_port_pkg::ST_ACQ) ||
                                 (state_ff == adc_port_pkg::ST_QUIET);
         read_n_ff            <= !((state_ff == adc_port_pkg::ST_RD) ||
                                   (state_ff == adc_port_pkg::ST_RD_LO));
         byte_sel_ff          <= (state_ff == adc_port_pkg::ST_RD_LO);
         powerdown_reset_n_ff <= (state_ff != adc_port_pkg::ST_PIN_LOW);
      end
   end

   // ************************************************************
   // result capture and status
   // ************************************************************
   // full word, or the high byte on the upper lanes then the low nibble on the same lanes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ff       <= 12'h000;
         result_valid_ff <= 1'b0;
      end else begin
         result_valid_ff <= 1'b0;
         if (state_ff == adc_port_pkg::ST_RD && done_cnt) begin
            if (byte_mode_ff)
               result_ff[11:4] <= data_sync_ff[11:4];
            else begin
               result_ff       <= data_sync_ff;
               result_valid_ff <= 1'b1;
            end
         end else if (state_ff == adc_port_pkg::ST_RD_LO && done_cnt) begin
            result_ff[3:0]  <= data_sync_ff[11:8];
            result_valid_ff <= 1'b1;
         end
      end
   end

   // status flags for the user side
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_ff        <= 1'b0;
         powered_down_ff <= 1'b0;
      end else begin
         ready_ff        <= (state_ff == adc_port_pkg::ST_IDLE) && !conv_req && !reset_req && !pdown_req;
         powered_down_ff <= (state_ff == adc_port_pkg::ST_PIN_LOW) && is_pdown_ff;
      end
   end

endmodule : adc_port_host

// ===== adc_port_host_assertions.sv
// checker for the converter host: pin sequencing seen at the controller's own ports
// assumes it is bound onto adc_port_host and sees nothing but that module's ports
`timescale 1ns/1ps
module adc_port_host_assertions (
   input wire logic core_clk,             // core clock
   input wire logic rst_n,                // async reset, active low
   input wire logic busy_pin,             // device busy
   input wire logic select_n_ff,          // chip select, active low
   input wire logic sample_trigger_ff,    // trigger pin
   input wire logic read_n_ff,            // read strobe, active low
   input wire logic byte_sel_ff,          // byte select
   input wire logic powerdown_reset_n_ff, // power-down/reset pin
   input wire logic result_valid_ff       // result pulse
);
   // ************************************************************
   // low-time counter for the power-down/reset line
   // ************************************************************
   logic [12:0] low_cnt_ff; // saturates, so a long power-down never wraps into the reset window
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_ff <= 13'h0000;
      end else if (powerdown_reset_n_ff) begin
         low_cnt_ff <= 13'h0000;
      end else if (low_cnt_ff != 13'h1FFF) begin
         low_cnt_ff <= low_cnt_ff + 13'h0001;
      end
   end
   // ************************************************************
   // pin timing
   // ************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_sel_held_low: assert property ($fell(select_n_ff) |-> !select_n_ff[*3])
      else $error("select low too short");
   a_trig_high_width: assert property ($rose(sample_trigger_ff) |-> sample_trigger_ff[*8])
      else $error("trigger high too short");
   a_trig_low_width: assert property ($fell(sample_trigger_ff) |-> !sample_trigger_ff[*3])
      else $error("trigger low too short");
   a_conv_while_sel: assert property ($fell(sample_trigger_ff) |-> !select_n_ff)
      else $error("trigger fell with device not selected");
   a_trig_before_sel: assert property ($fell(select_n_ff) |-> sample_trigger_ff && $past(sample_trigger_ff))
      else $error("select fell without the trigger already high");
   a_quiet_before_conv: assert property ($fell(sample_trigger_ff) |->
      $past(read_n_ff) && $past(read_n_ff, 2) && $past(read_n_ff, 3) && $past(read_n_ff, 4))
      else $error("bus activity in quiet period");
   a_read_after_busy: assert property ($fell(read_n_ff) |-> !$past(busy_pin, 2))
      else $error("read started while busy");
   a_read_selected: assert property (!read_n_ff |-> !select_n_ff)
      else $error("read strobe without select");
   a_read_length: assert property ($fell(read_n_ff) |-> !read_n_ff[*4])
      else $error("read strobe shorter than data valid time");
   a_byte_in_read: assert property ($rose(byte_sel_ff) |-> !read_n_ff && !select_n_ff)
      else $error("byte select raised outside a read");
   a_valid_from_read: assert property (result_valid_ff |-> !$past(read_n_ff))
      else $error("result without a read");
   a_reset_pulse_min: assert property ($fell(powerdown_reset_n_ff) |-> !powerdown_reset_n_ff[*6])
      else $error("reset pulse too short");
   a_no_gap_pulse: assert property ($rose(powerdown_reset_n_ff) |-> low_cnt_ff <= 13'h02FF
      || low_cnt_ff >= 13'h0384)
      else $error("line low time between reset and power-down");
endmodule : adc_port_host_assertions

bind adc_port_host adc_port_host_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .busy_pin(busy_pin),
   .select_n_ff(select_n_ff), .sample_trigger_ff(sample_trigger_ff), .read_n_ff(read_n_ff),
   .byte_sel_ff(byte_sel_ff), .powerdown_reset_n_ff(powerdown_reset_n_ff), .result_valid_ff(result_valid_ff));

// ===== adc_device_model.sv
// behavioural model of the converter pins: busy, data bus and power-down/reset decoding
// assumes no clock; all delays are ns and sit inside the documented maxima
`timescale 1ns/1ps
module adc_device_model (
   input  wire logic        select_n,          // chip select, active low
   input  wire logic        sample_trigger,    // trigger pin
   input  wire logic        read_n,            // read strobe, active low
   input  wire logic        byte_sel,          // byte select
   input  wire logic        powerdown_reset_n, // power-down/reset pin
   input  wire logic        slow,              // 1 = longest conversion time
   input  wire logic [11:0] analog_code,       // value the next conversion returns
   output logic             busy,              // busy pin
   output logic [11:0]      result_bus,        // data bus
   output int               reset_count,       // reset pulses decoded
   output int               pdown_count        // power-downs decoded
);
   logic [11:0] conv_result;  // last completed result
   logic        acquiring;    // tracking the input
   int          gen;          // bumps on start, abort or reset so stale completions drop out
   realtime     low_since;    // when the power-down/reset line fell
   initial begin
      busy = 1'b0;
      result_bus = 12'h5A5;
      conv_result = 12'h000;
      reset_count = 0;
      pdown_count = 0;
      gen = 0;
   end
   // completion: slow mode uses the full conversion time
   task automatic finish_conv(input int g, input logic [11:0] code);
      #(slow ? 280 : 100);
      if (g == gen) begin
         conv_result = code;
         busy <= #15 1'b0;
      end
   endtask : finish_conv
   task automatic start_conv();
      gen++;
      busy <= #30 1'b1;
      fork
         finish_conv(gen, analog_code);
      join_none
   endtask : start_conv
   // acquisition follows trigger rise or select fall
   always @(posedge sample_trigger or negedge select_n) begin
      acquiring <= #4 sample_trigger && !select_n;
   end
   always @(negedge sample_trigger) begin
      if (!select_n && powerdown_reset_n) begin
         start_conv();
      end
   end
   // select fall: abort a running conversion, or start one when trigger is low
   always @(negedge select_n) begin
      if (sample_trigger && busy) begin
         gen++;
         busy <= #15 1'b0;
      end else if (!sample_trigger) begin
         start_conv();
      end
   end
   // released bus shows a changing pattern, inverted on each select, strobe, byte select or busy change
   always @(select_n, read_n, byte_sel, busy) begin
      if (!select_n && !read_n) begin
         result_bus <= #10 byte_sel ? {conv_result[3:0], 8'h00} : conv_result;
      end else begin
         result_bus <= #10 ~result_bus;
      end
   end
   always @(negedge powerdown_reset_n) begin
      low_since = $realtime;
      gen++;
      busy <= 1'b0;
   end
   always @(posedge powerdown_reset_n) begin
      if ($realtime - low_since >= 7200.0) begin
         pdown_count++;
      end else if ($realtime - low_since >= 45.0 && $realtime - low_since <= 6140.0) begin
         reset_count++;
      end
   end
endmodule : adc_device_model

// ===== adc_parallel_conversion_port_bench.sv
// self-checking bench for the converter host controller against the device model
// assumes a 125 MHz core clock and the hand-over walk of the controller
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module adc_parallel_conversion_port_bench;
   logic        core_clk = 1'b0;    // core clock
   logic        rst_n = 1'b0;       // reset, active low
   logic        conv_req = 1'b0;    // conversion request
   logic        byte_mode = 1'b0;   // two byte reads
   logic        reset_req = 1'b0;   // reset pulse request
   logic        pdown_req = 1'b0;   // power-down request
   logic        slow = 1'b0;        // slow device conversion
   logic [11:0] analog_code = 12'h000; // device input value
   logic        busy, sel_n, trig, rd_n, bsel, pd_n, ready_ff, valid_ff, pdn_ff; // pins and status
   logic [11:0] bus, result_ff;     // data bus and collected result
   int          num_errors = 0;     // mismatches
   int          comparisons = 0;    // comparisons made
   always #4 core_clk = ~core_clk;
   adc_port_host dut (.core_clk(core_clk), .rst_n(rst_n), .conv_req(conv_req), .byte_mode(byte_mode),
      .reset_req(reset_req), .pdown_req(pdown_req), .busy_pin(busy), .result_bus_in(bus),
      .select_n_ff(sel_n), .sample_trigger_ff(trig), .read_n_ff(rd_n), .byte_sel_ff(bsel),
      .powerdown_reset_n_ff(pd_n), .ready_ff(ready_ff), .result_valid_ff(valid_ff),
      .result_ff(result_ff), .powered_down_ff(pdn_ff));
   adc_device_model u_dev (.select_n(sel_n), .sample_trigger(trig), .read_n(rd_n), .byte_sel(bsel),
      .powerdown_reset_n(pd_n), .slow(slow), .analog_code(analog_code), .busy(busy), .result_bus(bus),
      .reset_count(), .pdown_count());
   task conclude();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   // bounded wait: 0 ready, 1 result pulse, 2 powered down
   task wait_for(input int which, input int limit);
      for (int i = 0; i < limit; i++) begin
         @(posedge core_clk);
         if ((which == 0 ? ready_ff : which == 1 ? valid_ff : pdn_ff) === 1'b1) return;
      end
      num_errors++;
      $display("MISMATCH at %0t: wait %0d timed out", $time, which);
      conclude();
   endtask : wait_for
   // one conversion and read; poke pulses a reset request mid-sequence, which must be ignored
   task convert(input logic bm, input logic sl, input logic [11:0] code, input logic poke);
      wait_for(0, 3000);
      analog_code <= code;
      byte_mode <= bm;
      slow <= sl;
      conv_req <= 1'b1;
      @(posedge core_clk);
      conv_req <= 1'b0;
      if (poke) begin
         repeat (3) @(posedge core_clk);
         reset_req <= 1'b1;
         @(posedge core_clk);
         reset_req <= 1'b0;
      end
      wait_for(1, 500);
      `CHECK(result_ff, code)
   endtask : convert
   task test_word();
      convert(1'b0, 1'b0, 12'hA5C, 1'b0);
      convert(1'b0, 1'b1, 12'h000, 1'b0);
      convert(1'b0, 1'b0, 12'hFFF, 1'b0);
      $display("test_word done");
   endtask : test_word
   task test_byte();
      convert(1'b1, 1'b0, 12'h7E3, 1'b0);
      convert(1'b1, 1'b1, 12'h81C, 1'b0);
      $display("test_byte done");
   endtask : test_byte
   task test_refuse();
      convert(1'b0, 1'b1, 12'h5A3, 1'b1);
      `CHECK(u_dev.reset_count, 0)
      $display("test_refuse done");
   endtask : test_refuse
   task test_reset();
      wait_for(0, 3000);
      reset_req <= 1'b1;
      @(posedge core_clk);
      reset_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      wait_for(0, 3000);
      `CHECK(u_dev.reset_count, 1)
      `CHECK(u_dev.pdown_count, 0)
      $display("test_reset done");
   endtask : test_reset
   task test_pdown();
      wait_for(0, 3000);
      pdown_req <= 1'b1;
      wait_for(2, 1200);
      repeat (950) @(posedge core_clk);
      `CHECK(pd_n, 1'b0)
      pdown_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      wait_for(0, 3000);
      `CHECK(pdn_ff, 1'b0)
      `CHECK(u_dev.pdown_count, 1)
      convert(1'b0, 1'b0, 12'h3C1, 1'b0);
      $display("test_pdown done");
   endtask : test_pdown
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      test_word();
      test_byte();
      test_refuse();
      test_reset();
      test_pdown();
      conclude();
   end
endmodule : adc_parallel_conversion_port_bench
